// *** rt_mem_regs.svh ***
// Fixed shared-RAM map, descriptor layout and register offsets for the
// remote-terminal memory manager. Assumes 16-bit word addressing of RAM.
`ifndef RT_MEM_REGS_SVH
`define RT_MEM_REGS_SVH

`define SP_A_ADDR 16'h0100
`define SP_B_ADDR 16'h0104
`define MCI_BASE 16'h0108
`define MC_DATA_BASE 16'h0110
`define LUT_A_BASE 16'h0140
`define LUT_B_BASE 16'h01c0
`define BUSY_BASE 16'h0240
`define ILL_BASE 16'h0300
`define LUT_RX_OFS 16'h0000
`define LUT_TX_OFS 16'h0020
`define LUT_BC_OFS 16'h0040
`define LUT_CW_OFS 16'h0060

`define DESC_STATUS 16'h0000
`define DESC_TTAG 16'h0001
`define DESC_PTR 16'h0002
`define DESC_CMD 16'h0003
`define DESC_LEN 16'h0004
`define BSW_START 16'h8000
`define BSW_DONE 16'h4000
`define BSW_ERR_BIT 12
`define BSW_ILL_BIT 8
`define BSW_ROLL_BIT 4

`define STACK_MIN 16'h0100
`define CIRC_UNIT 16'h0040
`define DBL_TOGGLE 16'h0020

`define APB_CONFIG 8'h00
`define APB_STATUS 8'h04
`define CFG_RESET 16'h0001
`define CFG_LEGACY 0
`define CFG_SEP_BCST 1
`define CFG_ILL_EN 2
`define CFG_UPD_INVALID 3
`define CFG_STK_LO 4
`define CFG_STK_HI 5
`define CFG_AREA_B 13

`define CW_DBL 15
`define CW_TX_EOM 14
`define CW_TX_CIRC 13
`define CW_TX_MM_HI 12
`define CW_TX_MM_LO 10
`define CW_RX_EOM 9
`define CW_RX_CIRC 8
`define CW_RX_MM_HI 7
`define CW_RX_MM_LO 5
`define CW_BC_EOM 4
`define CW_BC_CIRC 3
`define CW_BC_MM_HI 2
`define CW_BC_MM_LO 0

`define CMD_TR 10
`define SA_HI 9
`define SA_LO 5
`define SA_MODE0 5'h00
`define SA_MODE31 5'h1f
`define WC_MSB 4

`endif

// *** rt_mem_pkg.sv ***
// Types for the remote-terminal memory manager.
// Assumes 16-bit shared RAM words and a 32-bit APB register bus.
package rt_mem_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_SP = 4'h1,
    ST_WR_D0 = 4'h3,
    ST_WR_D1 = 4'h2,
    ST_RD_CW = 4'h6,
    ST_RD_ILL = 4'h7,
    ST_RD_MC = 4'h5,
    ST_RD_PTR = 4'h4,
    ST_WR_D2 = 4'hc,
    ST_WR_D3 = 4'hd,
    ST_WAIT_END = 4'hf,
    ST_WR_PTR = 4'he,
    ST_WR_D0E = 4'ha,
    ST_WR_SP = 4'hb
  } state_t;

  typedef struct packed {
    state_t state;
    logic busy;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] sp;
    logic [15:0] cmd;
    logic bcst;
    logic [15:0] cw;
    logic [15:0] ptr;
    logic [15:0] last_ptr;
    logic illegal;
    logic mc_bit;
    logic ok;
    logic roll;
    logic ptr_vld;
    logic ev_eom;
    logic ev_roll;
    logic ev_mc;
    logic [15:0] cfg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mm_state_t;

endpackage

// *** rt_subaddress_memory_manager.sv ***
// Remote-terminal memory manager: per command, walks the fixed lookup
// tables in shared RAM, writes the message descriptor and updates pointers.
// Assumes a protocol engine on the command side, a request/acknowledge RAM
// port, and an APB master for configuration; all on one clock.
`timescale 1ns/1ps
`default_nettype none

`include "rt_mem_regs.svh"

module rt_subaddress_memory_manager #(
  parameter int ADDR_W = 16,
  parameter int MAX_WORDS = 32
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_word,
  input wire logic i_cmd_bcst,
  input wire logic [15:0] i_time_tag,
  input wire logic i_msg_done,
  input wire logic i_msg_ok,
  input wire logic [5:0] i_msg_words,
  output logic o_busy,
  output logic o_ptr_valid,
  output logic [15:0] o_data_ptr,
  output logic o_illegal,
  output logic o_ram_req,
  output logic o_ram_we,
  output logic [ADDR_W-1:0] o_ram_addr,
  output logic [15:0] o_ram_wdata,
  input wire logic i_ram_ack,
  input wire logic [15:0] i_ram_rdata,
  output logic o_event_eom,
  output logic o_event_rollover,
  output logic o_event_mode
);
  import rt_mem_pkg::*;

  generate
    if (ADDR_W != 16 || MAX_WORDS < 1 || MAX_WORDS > 32) begin : g_chk
      $error("Unsupported ADDR_W or MAX_WORDS");
    end
  endgenerate

  localparam logic [5:0] MAX_W = 6'(MAX_WORDS);

  mm_state_t s_q;
  mm_state_t s_d;

  logic [4:0] sa;
  logic tr;
  logic mode_cmd;
  logic sep_bc;
  logic legacy;
  logic ill_en;
  logic [15:0] lut_base;
  logic [15:0] lut_entry;
  logic [15:0] cw_addr;
  logic [2:0] scheme;
  logic eom_en;
  logic circ_en;
  logic dbl_en;
  logic [15:0] circ_mask;
  logic [15:0] circ_sum;
  logic [15:0] stk_mask;
  logic [15:0] acc_addr;
  logic acc_we;
  logic [15:0] acc_wd;
  logic [5:0] words;
  logic [15:0] end_bsw;
  logic apb_setup;
  logic apb_write;

  always_comb begin
    sa = s_q.cmd[`SA_HI:`SA_LO];
    tr = s_q.cmd[`CMD_TR];
    mode_cmd = (sa == `SA_MODE0) || (sa == `SA_MODE31);
    sep_bc = s_q.bcst && s_q.cfg[`CFG_SEP_BCST];
    legacy = s_q.cfg[`CFG_LEGACY];
    ill_en = s_q.cfg[`CFG_ILL_EN];
    lut_base = s_q.cfg[`CFG_AREA_B] ? `LUT_B_BASE : `LUT_A_BASE;
    // Section select by direction and broadcast, then subaddress
    if (tr) begin
      lut_entry = lut_base + `LUT_TX_OFS + {11'h000, sa};
    end else if (sep_bc) begin
      lut_entry = lut_base + `LUT_BC_OFS + {11'h000, sa};
    end else begin
      lut_entry = lut_base + `LUT_RX_OFS + {11'h000, sa};
    end
    cw_addr = lut_base + `LUT_CW_OFS + {11'h000, sa};
    // Per-direction buffer scheme and interrupt enables
    if (tr) begin
      scheme = s_q.cw[`CW_TX_MM_HI:`CW_TX_MM_LO];
      eom_en = s_q.cw[`CW_TX_EOM];
      circ_en = s_q.cw[`CW_TX_CIRC];
      dbl_en = 1'b0;
    end else if (sep_bc) begin
      scheme = s_q.cw[`CW_BC_MM_HI:`CW_BC_MM_LO];
      eom_en = s_q.cw[`CW_BC_EOM];
      circ_en = s_q.cw[`CW_BC_CIRC];
      dbl_en = s_q.cw[`CW_DBL];
    end else begin
      scheme = s_q.cw[`CW_RX_MM_HI:`CW_RX_MM_LO];
      eom_en = s_q.cw[`CW_RX_EOM];
      circ_en = s_q.cw[`CW_RX_CIRC];
      dbl_en = s_q.cw[`CW_DBL];
    end
    circ_mask = (`CIRC_UNIT << scheme) - 16'h0001;
    words = (i_msg_words > MAX_W) ? MAX_W : i_msg_words;
    circ_sum = s_q.ptr + {10'h000, words};
    stk_mask = (`STACK_MIN << s_q.cfg[`CFG_STK_HI:`CFG_STK_LO]) - 16'h0001;
    end_bsw = `BSW_DONE;
    end_bsw[`BSW_ERR_BIT] = ~s_q.ok;
    end_bsw[`BSW_ILL_BIT] = s_q.illegal;
    end_bsw[`BSW_ROLL_BIT] = s_q.roll;

    // Address and data of the RAM access each state performs
    acc_we = 1'b1;
    acc_wd = 16'h0000;
    acc_addr = 16'h0000;
    case (s_q.state)
      ST_RD_SP: begin
        acc_we = 1'b0;
        acc_addr = s_q.cfg[`CFG_AREA_B] ? `SP_B_ADDR : `SP_A_ADDR;
      end
      ST_WR_D0: begin
        acc_addr = s_q.sp + `DESC_STATUS;
        acc_wd = `BSW_START;
      end
      ST_WR_D1: begin
        acc_addr = s_q.sp + `DESC_TTAG;
        acc_wd = i_time_tag;
      end
      ST_RD_CW: begin
        acc_we = 1'b0;
        acc_addr = cw_addr;
      end
      ST_RD_ILL: begin
        acc_we = 1'b0;
        acc_addr = `ILL_BASE +
          {8'h00, s_q.bcst, tr, sa, s_q.cmd[`WC_MSB]};
      end
      ST_RD_MC: begin
        acc_we = 1'b0;
        acc_addr = `MCI_BASE + {13'h0000, s_q.bcst, tr, s_q.cmd[`WC_MSB]};
      end
      ST_RD_PTR: begin
        acc_we = 1'b0;
        acc_addr = lut_entry;
      end
      ST_WR_D2: begin
        acc_addr = s_q.sp + `DESC_PTR;
        acc_wd = s_q.ptr;
      end
      ST_WR_D3: begin
        acc_addr = s_q.sp + `DESC_CMD;
        acc_wd = s_q.cmd;
      end
      ST_WR_PTR: begin
        acc_addr = lut_entry;
        acc_wd = s_q.ptr;
      end
      ST_WR_D0E: begin
        acc_addr = s_q.sp + `DESC_STATUS;
        acc_wd = end_bsw;
      end
      ST_WR_SP: begin
        acc_addr = s_q.cfg[`CFG_AREA_B] ? `SP_B_ADDR : `SP_A_ADDR;
        acc_wd = (s_q.sp & ~stk_mask) |
          ((s_q.sp + `DESC_LEN) & stk_mask);
      end
      default: begin
        acc_we = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ev_eom = 1'b0;
    s_d.ev_roll = 1'b0;
    s_d.ev_mc = 1'b0;

    // APB slave, answers in the first access cycle
    apb_setup = i_psel && !i_penable && !s_q.pready;
    apb_write = i_psel && i_penable && s_q.pready && i_pwrite;
    s_d.pready = apb_setup;
    if (apb_setup) begin
      s_d.pslverr = 1'b0;
      case (i_paddr)
        `APB_CONFIG: s_d.prdata = {16'h0000, s_q.cfg};
        `APB_STATUS: s_d.prdata = {s_q.last_ptr, 13'h0000,
          s_q.illegal, s_q.ptr_vld, (s_q.state != ST_IDLE)};
        default: begin
          s_d.prdata = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_write && i_paddr == `APB_CONFIG) begin
      s_d.cfg = i_pwdata[15:0];
    end

    if (s_q.state == ST_IDLE) begin
      if (i_cmd_valid) begin
        s_d.cmd = i_cmd_word;
        s_d.bcst = i_cmd_bcst;
        s_d.cw = 16'h0000;
        s_d.illegal = 1'b0;
        s_d.mc_bit = 1'b0;
        s_d.roll = 1'b0;
        s_d.state = ST_RD_SP;
      end
    end else if (s_q.state == ST_WAIT_END) begin
      if (i_msg_done) begin
        s_d.ptr_vld = 1'b0;
        s_d.ok = i_msg_ok;
        s_d.state = ST_WR_D0E;
        if (!mode_cmd && scheme != 3'h0 &&
            (i_msg_ok || s_q.cfg[`CFG_UPD_INVALID])) begin
          s_d.ptr = (s_q.ptr & ~circ_mask) | (circ_sum & circ_mask);
          s_d.roll = (circ_sum & ~circ_mask) != (s_q.ptr & ~circ_mask);
          s_d.state = ST_WR_PTR;
        end else if (!mode_cmd && scheme == 3'h0 && dbl_en && i_msg_ok) begin
          s_d.ptr = s_q.ptr ^ `DBL_TOGGLE;
          s_d.state = ST_WR_PTR;
        end
      end
    end else if (!s_q.req) begin
      s_d.req = 1'b1;
      s_d.we = acc_we;
      s_d.addr = acc_addr;
      s_d.wdata = acc_wd;
    end else if (i_ram_ack) begin
      s_d.req = 1'b0;
      s_d.we = 1'b0;
      case (s_q.state)
        ST_RD_SP: begin
          s_d.sp = i_ram_rdata;
          s_d.state = ST_WR_D0;
        end
        ST_WR_D0: s_d.state = ST_WR_D1;
        ST_WR_D1: begin
          if (mode_cmd) begin
            s_d.state = ill_en ? ST_RD_ILL : ST_RD_MC;
          end else if (legacy) begin
            s_d.state = ill_en ? ST_RD_ILL : ST_RD_PTR;
          end else begin
            s_d.state = ST_RD_CW;
          end
        end
        ST_RD_CW: begin
          s_d.cw = i_ram_rdata;
          s_d.state = ill_en ? ST_RD_ILL : ST_RD_PTR;
        end
        ST_RD_ILL: begin
          s_d.illegal = i_ram_rdata[s_q.cmd[3:0]];
          s_d.state = mode_cmd ? ST_RD_MC : ST_RD_PTR;
        end
        ST_RD_MC: begin
          s_d.mc_bit = i_ram_rdata[s_q.cmd[3:0]];
          s_d.ptr = `MC_DATA_BASE + {11'h000, tr, s_q.cmd[3:0]};
          s_d.state = ST_WR_D2;
        end
        ST_RD_PTR: begin
          s_d.ptr = i_ram_rdata;
          s_d.state = ST_WR_D2;
        end
        ST_WR_D2: s_d.state = ST_WR_D3;
        ST_WR_D3: begin
          s_d.ptr_vld = 1'b1;
          s_d.last_ptr = s_q.ptr;
          s_d.state = ST_WAIT_END;
        end
        ST_WR_PTR: s_d.state = ST_WR_D0E;
        ST_WR_D0E: s_d.state = ST_WR_SP;
        ST_WR_SP: begin
          s_d.sp = acc_wd;
          s_d.ev_eom = eom_en;
          s_d.ev_roll = s_q.roll && circ_en;
          s_d.ev_mc = s_q.mc_bit && mode_cmd;
          s_d.state = ST_IDLE;
        end
        default: s_d.state = ST_IDLE;
      endcase
    end
    // Busy kept in its own flop so the port is registered
    s_d.busy = (s_d.state != ST_IDLE);
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.cfg <= `CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_busy = s_q.busy;
  assign o_ptr_valid = s_q.ptr_vld;
  assign o_data_ptr = s_q.last_ptr;
  assign o_illegal = s_q.illegal;
  assign o_ram_req = s_q.req;
  assign o_ram_we = s_q.we;
  assign o_ram_addr = s_q.addr;
  assign o_ram_wdata = s_q.wdata;
  assign o_event_eom = s_q.ev_eom;
  assign o_event_rollover = s_q.ev_roll;
  assign o_event_mode = s_q.ev_mc;

endmodule // rt_subaddress_memory_manager

`default_nettype wire

// *** rt_mm_properties.sv ***
// Port assertions for the RT memory manager.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rt_mm_properties #(
  parameter int ADDR_W = 16,
  parameter int MAX_WORDS = 32
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_cmd_valid,
  input wire logic i_msg_done,
  input wire logic o_busy,
  input wire logic o_ptr_valid,
  input wire logic o_ram_req,
  input wire logic o_ram_we,
  input wire logic [ADDR_W-1:0] o_ram_addr,
  input wire logic [15:0] o_ram_wdata,
  input wire logic i_ram_ack,
  input wire logic o_event_eom
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_take;
    i_cmd_valid && !o_busy;
  endsequence
  sequence s_sp_read;
    o_ram_req && !o_ram_we && o_ram_addr inside {16'h0100, 16'h0104};
  endsequence
  a_sp_fetch_first: assert property (s_take |=> o_busy ##1 s_sp_read)
    else $error("stack pointer not read first");
  a_apb_zero_wait: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  a_pready_single: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (o_pready |->
    o_pslverr == !(i_paddr inside {8'h00, 8'h04}))
    else $error("slave error wrong");
  a_req_held: assert property (o_ram_req && !i_ram_ack |=> o_ram_req
    && $stable(o_ram_addr) && $stable(o_ram_we) && $stable(o_ram_wdata))
    else $error("ram request changed");
  a_req_release: assert property (o_ram_req && i_ram_ack |=> !o_ram_req)
    else $error("ram request not released");
  a_ptr_until_done: assert property (o_ptr_valid && i_msg_done |=>
    !o_ptr_valid)
    else $error("pointer valid after done");
  a_ptr_in_busy: assert property (o_ptr_valid |-> o_busy)
    else $error("pointer valid while idle");
  a_eom_single: assert property (o_event_eom |=> !o_event_eom)
    else $error("end event too long");
endmodule // rt_mm_properties
bind rt_subaddress_memory_manager rt_mm_properties #(.ADDR_W(ADDR_W),
  .MAX_WORDS(MAX_WORDS)) rt_mm_properties_i (.*);
`default_nettype wire

// *** rt_ram_model.sv ***
// Shared RAM seen by the manager; the bench writes it as the host would.
// Assumes requests are held until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module rt_ram_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:16383];
  int wait_n;
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 16'h0000;
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    wait_n = 0;
  end
  always @(posedge i_clock) begin
    if (o_ack) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;  // Read data gone after the answer
    end else if (i_req && wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (i_req) begin
      o_ack <= 1'b1;
      wait_n <= i_slow ? 3 : 0;
      if (i_we) mem[i_addr[13:0]] <= i_wdata;
      else o_rdata <= mem[i_addr[13:0]];
    end
  end
endmodule // rt_ram_model
`default_nettype wire

// *** tb_rt_subaddress_memory_manager.sv ***
// Bench for the RT memory manager: APB setup, RAM model, message runs.
// Assumes the property checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "rt_mem_regs.svh"
module tb_rt_subaddress_memory_manager;
  import rt_mem_pkg::*;
  logic i_clock, i_reset_n, i_psel, i_penable, i_pwrite, i_cmd_valid;
  logic i_cmd_bcst, i_msg_done, i_msg_ok, i_ram_ack, o_pready, o_pslverr;
  logic o_busy, o_ptr_valid, o_illegal, o_ram_req, o_ram_we, o_event_eom;
  logic o_event_rollover, o_event_mode, slow, pv_q, er, bc;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [15:0] i_cmd_word, i_time_tag, o_data_ptr, o_ram_addr, o_ram_wdata;
  logic [15:0] i_ram_rdata, spa, spv, idx, ptr, cmd, sz, cw;
  logic [5:0] i_msg_words;
  logic [15:0] exp_q[$];
  int err_total, comparisons, n_eom, n_roll, n_mode, e0, r0, sa;
  rt_subaddress_memory_manager rt_subaddress_memory_manager_i (.*);
  rt_ram_model rt_ram_model_i (.i_clock(i_clock), .i_slow(slow),
    .i_req(o_ram_req), .i_we(o_ram_we), .i_addr(o_ram_addr),
    .i_wdata(o_ram_wdata), .o_ack(i_ram_ack), .o_rdata(i_ram_rdata));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  function automatic logic [15:0] m(input logic [15:0] a);
    return rt_ram_model_i.mem[a[13:0]];
  endfunction
  task automatic w(input logic [15:0] a, input logic [15:0] d);
    rt_ram_model_i.mem[a[13:0]] = d;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Pointer notes checked as each message offers its block
  always @(posedge i_clock) begin
    pv_q <= o_ptr_valid;
    n_eom += int'(o_event_eom === 1'b1);
    n_roll += int'(o_event_rollover === 1'b1);
    n_mode += int'(o_event_mode === 1'b1);
    if (o_ptr_valid === 1'b1 && pv_q !== 1'b1) begin
      if (exp_q.size() == 0) chk(o_data_ptr, 32'hffffffff);
      else chk(o_data_ptr, exp_q.pop_front());
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic prep(input logic a, t, b, input logic [15:0] c, p);
    logic [15:0] base;
    sa = (c == 16'h0000 && !b) ? 30 : 1 + $urandom % 29;
    base = a ? `LUT_B_BASE : `LUT_A_BASE;
    spa = a ? `SP_B_ADDR : `SP_A_ADDR;
    bc = b;
    w(spa, a ? 16'h3e00 : 16'h3f00);
    idx = base + (b ? `LUT_BC_OFS : t ? `LUT_TX_OFS : `LUT_RX_OFS) + 16'(sa);
    w(idx, p);
    w(base + `LUT_CW_OFS + 16'(sa), c);
    cmd = {b ? 5'h1f : 5'h05, t, 5'(sa), 5'h08};
  endtask
  task automatic msg(input logic ok, input logic [15:0] p);
    int n;
    n = 0;
    ptr = p;
    spv = m(spa);
    exp_q.push_back(p);
    slow <= 1'($urandom % 2);
    i_time_tag <= 16'($urandom);
    i_cmd_word <= cmd;
    i_cmd_bcst <= bc;
    i_cmd_valid <= 1'b1;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    while (o_ptr_valid !== 1'b1 && n < 300) begin
      @(posedge i_clock);
      n++;
    end
    i_msg_ok <= ok;
    i_msg_words <= 6'd8;
    i_msg_done <= 1'b1;
    @(posedge i_clock);
    i_msg_done <= 1'b0;
    while (o_busy !== 1'b0 && n < 600) begin
      @(posedge i_clock);
      n++;
    end
    @(posedge i_clock);
    if (n >= 600) err_total++;
  endtask
  task automatic post(input logic [15:0] lut);
    chk(m(spv + 16'h0003), cmd);
    chk(m(spv + 16'h0002), ptr);
    chk(m(spv) & 16'h4000, 32'h4000);
    chk(m(spa), {spv[15:8], spv[7:0] + 8'h04});
    chk(m(idx), lut);
    chk(o_illegal, 32'h0);
  endtask
  initial begin
    {i_psel, i_penable, i_pwrite, i_cmd_valid, i_cmd_bcst} = '0;
    {i_msg_done, i_msg_ok, slow, i_reset_n} = '0;
    {i_paddr, i_pwdata, i_cmd_word, i_time_tag, i_msg_words} = '0;
    void'($urandom(61));
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    apb(1'b0, `APB_CONFIG, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk(er, 32'h1);
    $display("Registers done");
    for (int a = 0; a < 2; a++) begin
      for (int t = 0; t < 2; t++) begin
        apb(1'b1, `APB_CONFIG, a ? 32'h2001 : 32'h1);
        ptr = 16'h0400 + 16'(($urandom % 400) << 5);
        prep(1'(a), 1'(t), 1'b0, 16'h0021, ptr);
        msg(1'b1, ptr);
        post(ptr);
      end
    end
    $display("Single message done");
    apb(1'b1, `APB_CONFIG, 32'h0);
    for (int s = 1; s < 8; s++) begin
      sz = 16'h0040 << s;
      cw = s[0] ? (16'(s) << 10) | 16'h6000 : (16'(s) << 5) | 16'h0300;
      prep(1'b0, s[0], 1'b0, cw, 2 * sz - 16'h4);
      e0 = n_eom;
      r0 = n_roll;
      msg(1'b1, 2 * sz - 16'h4);
      post(sz + 16'h4);
      chk(n_roll - r0, 32'h1);
      chk(n_eom - e0, 32'h1);
    end
    apb(1'b1, `APB_CONFIG, 32'h8);
    prep(1'b0, 1'b0, 1'b0, 16'h0020, 16'h0a00);
    msg(1'b0, 16'h0a00);
    post(16'h0a08);
    $display("Circular done");
    prep(1'b0, 1'b0, 1'b0, 16'h8000, 16'h0800);
    msg(1'b1, 16'h0800);
    post(16'h0820);
    msg(1'b0, 16'h0820);
    post(16'h0820);
    $display("Double buffer done");
    apb(1'b1, `APB_CONFIG, 32'h2002);
    prep(1'b1, 1'b0, 1'b1, 16'h0000, 16'h0c00);
    msg(1'b1, 16'h0c00);
    post(16'h0c00);
    apb(1'b1, `APB_CONFIG, 32'h4);
    prep(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0d00);
    w(16'h0300 + 16'(sa << 1), 16'h0100);
    msg(1'b1, 16'h0d00);
    chk(m(spv) & 16'h0100, 32'h0100);
    chk(o_illegal, 32'h1);
    $display("Broadcast and illegal done");
    apb(1'b1, `APB_CONFIG, 32'h10);
    cmd = 16'h0c02;
    w(16'h010a, 16'h0004);
    w(spa, 16'h3ffc);
    e0 = n_mode;
    msg(1'b1, 16'h0122);
    chk(m(spv + 16'h0002), 32'h0122);
    chk(m(spa), 32'h3e00);
    chk(n_mode - e0, 32'h1);
    chk(exp_q.size(), 32'h0);
    $display("Mode code done");
    give_verdict;
  end
  initial begin
    #(50 * 20000);
    err_total++;
    give_verdict;
  end
endmodule // tb_rt_subaddress_memory_manager
`default_nettype wire
